/* File: inc/pmae_defines.svh */
`ifndef PMAE_DEFINES_SVH
`define PMAE_DEFINES_SVH

// ****************************************
// Timing, in their own units and in cycles
// ****************************************
`define PMAE_CLK_HZ        40000000
`define PMAE_HOLD_MS       3000
`define PMAE_IDLE_MS       10000
`define PMAE_DBL_MS        400
`define PMAE_DEB_MS        20
`define PMAE_FLASH_MS      250
`define PMAE_STRETCH_MS    50
`define PMAE_MS_CYC        (`PMAE_CLK_HZ / 1000)
`define PMAE_CONFIRM_FLASH 3

// ****************************************
// Display codes
// ****************************************
`define PMAE_CODE_C        4'hC
`define PMAE_CODE_F        4'hF
`define PMAE_DIGIT_MAX     4'h9

`endif

/* File: inc/pmae_pkg.sv */
package pmae_pkg;

    typedef enum logic [1:0] {
        PMAE_MODE_RUN   = 2'h0,
        PMAE_MODE_CFG   = 2'h1,
        PMAE_MODE_DEBUG = 2'h2
    } pmae_mode_t;

    typedef enum logic [2:0] {
        PMAE_ST_SHOW    = 3'h0,
        PMAE_ST_TENS    = 3'h1,
        PMAE_ST_UNITS   = 3'h3,
        PMAE_ST_CONFIRM = 3'h2
    } pmae_state_t;

endpackage : pmae_pkg

/* File: logic/pmae_activity.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmae_defines.svh"

module pmae_activity #(
    parameter int STRETCH_CYC = 40
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic tick_ms,
    input  wire logic flash,
    input  wire logic busy,
    output logic      led
);
    logic [1:0] sync;
    logic [7:0] hold;

    // Synchronise the activity level
    always_ff @(posedge clk) begin
        if (rst) begin
            sync <= 2'h0;
        end else begin
            sync <= {sync[0], busy};
        end
    end

    // Stretch each burst to a visible length
    always_ff @(posedge clk) begin
        if (rst) begin
            hold <= 8'h00;
        end else if (sync[1]) begin
            hold <= 8'(STRETCH_CYC);
        end else if (tick_ms && hold != 8'h00) begin
            hold <= hold - 8'h01;
        end
    end

    // Blink while active, dark when idle
    always_ff @(posedge clk) begin
        if (rst) begin
            led <= 1'b0;
        end else begin
            led <= (hold != 8'h00) && flash;
        end
    end
endmodule : pmae_activity
`default_nettype wire

/* File: logic/pmae_panel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pmae_defines.svh"

module pmae_panel #(
    parameter int HOLD_MS = `PMAE_HOLD_MS,
    parameter int IDLE_MS = `PMAE_IDLE_MS,
    parameter int DBL_MS  = `PMAE_DBL_MS,
    parameter int DEB_MS  = `PMAE_DEB_MS,
    parameter int FLASH_MS = `PMAE_FLASH_MS,
    parameter int MS_CYC  = `PMAE_MS_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       sw_debug,
    input  wire logic       sw_config,
    input  wire logic       button,
    input  wire logic [3:0] stored_tens,
    input  wire logic [3:0] stored_units,
    input  wire logic       ser_tx_busy,
    input  wire logic       ser_rx_busy,
    input  wire logic       fb_tx_busy,
    input  wire logic       fb_rx_busy,
    output logic [1:0]      mode,
    output logic            comm_on_rs485,
    output logic            debug_on_rs232,
    output logic            cfg_on_rs232,
    output logic [3:0]      disp_tens,
    output logic [3:0]      disp_units,
    output logic            disp_tens_on,
    output logic            disp_units_on,
    output logic [6:0]      slave_addr,
    output logic            addr_write,
    output logic            ser_tx_led,
    output logic            ser_rx_led,
    output logic            fb_tx_led,
    output logic            fb_rx_led
);
    // ****************************************
    // Time base
    // ****************************************
    logic [15:0] pre_cnt;
    logic        tick_ms;
    logic [15:0] flash_cnt;
    logic        flash;

    // Millisecond enable pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            pre_cnt <= 16'h0000;
            tick_ms <= 1'b0;
        end else if (pre_cnt == 16'(MS_CYC - 1)) begin
            pre_cnt <= 16'h0000;
            tick_ms <= 1'b1;
        end else begin
            pre_cnt <= pre_cnt + 16'h0001;
            tick_ms <= 1'b0;
        end
    end

    // Flash phase for blinking digits and lamps
    always_ff @(posedge clk) begin
        if (rst) begin
            flash_cnt <= 16'h0000;
            flash     <= 1'b1;
        end else if (tick_ms) begin
            if (flash_cnt == 16'(FLASH_MS - 1)) begin
                flash_cnt <= 16'h0000;
                flash     <= ~flash;
            end else begin
                flash_cnt <= flash_cnt + 16'h0001;
            end
        end
    end

    // ****************************************
    // Mode capture
    // ****************************************
    logic [1:0] sw_sync0;
    logic [1:0] sw_sync1;
    logic [1:0] cap_wait;
    logic       captured;
    pmae_pkg::pmae_mode_t next_mode;

    // Switches through two flops
    always_ff @(posedge clk) begin
        if (rst) begin
            sw_sync0 <= 2'h0;
            sw_sync1 <= 2'h0;
        end else begin
            sw_sync0 <= {sw_config, sw_debug};
            sw_sync1 <= sw_sync0;
        end
    end

    // Decode of the synchronised switch pair
    always_comb begin
        if (sw_sync1[1]) begin
            next_mode = pmae_pkg::PMAE_MODE_CFG;
        end else if (sw_sync1[0]) begin
            next_mode = pmae_pkg::PMAE_MODE_DEBUG;
        end else begin
            next_mode = pmae_pkg::PMAE_MODE_RUN;
        end
    end

    // Latch once after reset release, then freeze
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_wait       <= 2'h0;
            captured       <= 1'b0;
            mode           <= pmae_pkg::PMAE_MODE_RUN;
            comm_on_rs485  <= 1'b0;
            debug_on_rs232 <= 1'b0;
            cfg_on_rs232   <= 1'b0;
        end else if (!captured) begin
            if (cap_wait == 2'h3) begin
                captured       <= 1'b1;
                mode           <= next_mode;
                comm_on_rs485  <= next_mode == pmae_pkg::PMAE_MODE_DEBUG;
                debug_on_rs232 <= next_mode == pmae_pkg::PMAE_MODE_DEBUG;
                cfg_on_rs232   <= next_mode == pmae_pkg::PMAE_MODE_CFG;
            end else begin
                cap_wait <= cap_wait + 2'h1;
            end
        end
    end

    // ****************************************
    // Button conditioning
    // ****************************************
    logic [1:0]  btn_sync;
    logic        btn_db;
    logic [7:0]  deb_cnt;
    logic        btn_prev;
    logic        press;
    logic        release_ev;
    logic [15:0] hold_cnt;
    logic        hold_done;
    logic        long_fired;

    always_ff @(posedge clk) begin
        if (rst) begin
            btn_sync <= 2'h0;
        end else begin
            btn_sync <= {btn_sync[0], button};
        end
    end

    // Debounce: level must stay for the debounce time
    always_ff @(posedge clk) begin
        if (rst) begin
            btn_db  <= 1'b0;
            deb_cnt <= 8'h00;
        end else if (btn_sync[1] == btn_db) begin
            deb_cnt <= 8'h00;
        end else if (tick_ms) begin
            if (deb_cnt == 8'(DEB_MS - 1)) begin
                btn_db  <= btn_sync[1];
                deb_cnt <= 8'h00;
            end else begin
                deb_cnt <= deb_cnt + 8'h01;
            end
        end
    end

    // Edges of the clean button
    always_ff @(posedge clk) begin
        if (rst) begin
            btn_prev   <= 1'b0;
            press      <= 1'b0;
            release_ev <= 1'b0;
        end else begin
            btn_prev   <= btn_db;
            press      <= btn_db && !btn_prev;
            // A release that ends a long hold is not a click
            release_ev <= !btn_db && btn_prev && !long_fired;
        end
    end

    // Long-press timer, one firing per hold
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_cnt   <= 16'h0000;
            hold_done  <= 1'b0;
            long_fired <= 1'b0;
        end else if (!btn_db) begin
            hold_cnt   <= 16'h0000;
            hold_done  <= 1'b0;
            long_fired <= 1'b0;
        end else if (tick_ms && !long_fired) begin
            if (hold_cnt == 16'(HOLD_MS - 1)) begin
                hold_done  <= 1'b1;
                long_fired <= 1'b1;
            end else begin
                hold_cnt <= hold_cnt + 16'h0001;
            end
        end else begin
            hold_done <= 1'b0;
        end
    end

    // ****************************************
    // Address entry
    // ****************************************
    pmae_pkg::pmae_state_t state;
    logic [15:0] dbl_cnt;
    logic        dbl_armed;
    logic [15:0] idle_cnt;
    logic [3:0]  edit_tens;
    logic [3:0]  edit_units;
    logic [2:0]  conf_left;
    logic        flash_prev;
    logic        short_click;
    logic        click_ok;

    // Only presses made inside the edit count as clicks
    always_ff @(posedge clk) begin
        if (rst || state == pmae_pkg::PMAE_ST_SHOW) begin
            click_ok <= 1'b0;
        end else if (press) begin
            click_ok <= 1'b1;
        end
    end

    assign short_click = release_ev && click_ok;

    // Double-press window, from the first press
    always_ff @(posedge clk) begin
        if (rst || state != pmae_pkg::PMAE_ST_SHOW) begin
            dbl_armed <= 1'b0;
            dbl_cnt   <= 16'h0000;
        end else if (press) begin
            dbl_armed <= !dbl_armed;
            dbl_cnt   <= 16'h0000;
        end else if (dbl_armed && tick_ms) begin
            if (dbl_cnt == 16'(DBL_MS - 1)) begin
                dbl_armed <= 1'b0;
            end else begin
                dbl_cnt <= dbl_cnt + 16'h0001;
            end
        end
    end

    // Idle timer during editing
    always_ff @(posedge clk) begin
        if (rst || press || btn_db) begin
            idle_cnt <= 16'h0000;
        end else if (tick_ms) begin
            idle_cnt <= idle_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flash_prev <= 1'b0;
        end else begin
            flash_prev <= flash;
        end
    end

    // Entry state machine
    always_ff @(posedge clk) begin
        if (rst) begin
            state      <= pmae_pkg::PMAE_ST_SHOW;
            edit_tens  <= 4'h0;
            edit_units <= 4'h0;
            conf_left  <= 3'h0;
            slave_addr <= 7'h00;
            addr_write <= 1'b0;
        end else begin
            addr_write <= 1'b0;
            case (state)
                pmae_pkg::PMAE_ST_SHOW: begin
                    slave_addr <= 7'(stored_tens) * 7'h0A
                        + 7'(stored_units);
                    if (captured && mode == pmae_pkg::PMAE_MODE_RUN
                        && press && dbl_armed) begin
                        edit_tens  <= stored_tens;
                        edit_units <= stored_units;
                        state      <= pmae_pkg::PMAE_ST_TENS;
                    end
                end
                pmae_pkg::PMAE_ST_TENS: begin
                    if (idle_cnt >= 16'(IDLE_MS)) begin
                        state <= pmae_pkg::PMAE_ST_SHOW;
                    end else if (hold_done) begin
                        state <= pmae_pkg::PMAE_ST_UNITS;
                    end else if (short_click) begin
                        edit_tens <= (edit_tens >= `PMAE_DIGIT_MAX)
                            ? 4'h0 : edit_tens + 4'h1;
                    end
                end
                pmae_pkg::PMAE_ST_UNITS: begin
                    if (idle_cnt >= 16'(IDLE_MS)) begin
                        state <= pmae_pkg::PMAE_ST_SHOW;
                    end else if (hold_done) begin
                        slave_addr <= 7'(edit_tens) * 7'h0A
                            + 7'(edit_units);
                        addr_write <= 1'b1;
                        conf_left  <= 3'(`PMAE_CONFIRM_FLASH);
                        state      <= pmae_pkg::PMAE_ST_CONFIRM;
                    end else if (short_click) begin
                        edit_units <= (edit_units >= `PMAE_DIGIT_MAX)
                            ? 4'h0 : edit_units + 4'h1;
                    end
                end
                pmae_pkg::PMAE_ST_CONFIRM: begin
                    if (flash && !flash_prev) begin
                        if (conf_left == 3'h1) begin
                            state <= pmae_pkg::PMAE_ST_SHOW;
                        end
                        conf_left <= conf_left - 3'h1;
                    end
                end
                default: state <= pmae_pkg::PMAE_ST_SHOW;
            endcase
        end
    end

    // ****************************************
    // Display drive
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            disp_tens     <= 4'h0;
            disp_units    <= 4'h0;
            disp_tens_on  <= 1'b0;
            disp_units_on <= 1'b0;
        end else if (captured && mode == pmae_pkg::PMAE_MODE_CFG) begin
            disp_tens     <= `PMAE_CODE_C;
            disp_units    <= `PMAE_CODE_F;
            disp_tens_on  <= 1'b1;
            disp_units_on <= 1'b1;
        end else begin
            case (state)
                pmae_pkg::PMAE_ST_TENS: begin
                    disp_tens     <= edit_tens;
                    disp_units    <= edit_units;
                    disp_tens_on  <= flash;
                    disp_units_on <= 1'b1;
                end
                pmae_pkg::PMAE_ST_UNITS: begin
                    disp_tens     <= edit_tens;
                    disp_units    <= edit_units;
                    disp_tens_on  <= 1'b1;
                    disp_units_on <= flash;
                end
                pmae_pkg::PMAE_ST_CONFIRM: begin
                    disp_tens     <= edit_tens;
                    disp_units    <= edit_units;
                    disp_tens_on  <= !flash;
                    disp_units_on <= !flash;
                end
                default: begin
                    disp_tens     <= stored_tens;
                    disp_units    <= stored_units;
                    disp_tens_on  <= captured;
                    disp_units_on <= captured;
                end
            endcase
        end
    end

    // ****************************************
    // Activity lamps
    // ****************************************
    localparam int STRETCH = `PMAE_STRETCH_MS;

    pmae_activity #(.STRETCH_CYC(STRETCH)) u_ser_tx (
        .clk(clk), .rst(rst), .tick_ms(tick_ms), .flash(flash),
        .busy(ser_tx_busy), .led(ser_tx_led));
    pmae_activity #(.STRETCH_CYC(STRETCH)) u_ser_rx (
        .clk(clk), .rst(rst), .tick_ms(tick_ms), .flash(flash),
        .busy(ser_rx_busy), .led(ser_rx_led));
    pmae_activity #(.STRETCH_CYC(STRETCH)) u_fb_tx (
        .clk(clk), .rst(rst), .tick_ms(tick_ms), .flash(flash),
        .busy(fb_tx_busy), .led(fb_tx_led));
    pmae_activity #(.STRETCH_CYC(STRETCH)) u_fb_rx (
        .clk(clk), .rst(rst), .tick_ms(tick_ms), .flash(flash),
        .busy(fb_rx_busy), .led(fb_rx_led));
endmodule : pmae_panel
`default_nettype wire

/* File: verif/pmae_panel_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// *****
// Port checker for the front panel
// *****
module pmae_panel_asserts #(
    parameter int MS_CYC = 4
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       ser_tx_busy,
    input wire logic [1:0] mode,
    input wire logic       comm_on_rs485,
    input wire logic       debug_on_rs232,
    input wire logic       cfg_on_rs232,
    input wire logic [3:0] disp_tens,
    input wire logic [3:0] disp_units,
    input wire logic       disp_tens_on,
    input wire logic [6:0] slave_addr,
    input wire logic       addr_write,
    input wire logic       ser_tx_led
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [31:0] idle_cyc;

    // Cycles since the serial sender was last busy
    always_ff @(posedge clk) begin
        if (rst || ser_tx_busy)
            idle_cyc <= 32'h0;
        else if (idle_cyc != 32'hFFFFFFFF)
            idle_cyc <= idle_cyc + 32'h1;
    end

    mode_hold_a: assert property (
        $past(mode) != 2'h0 |-> mode == $past(mode))
        else $error("mode changed after capture");
    run_route_a: assert property (
        mode == 2'h0 |-> !cfg_on_rs232 && !comm_on_rs485)
        else $error("port flags set in run mode");
    debug_route_a: assert property (
        mode == 2'h2 |-> ##2 (comm_on_rs485 && debug_on_rs232))
        else $error("debug mode routing wrong");
    cfg_route_a: assert property (
        mode == 2'h1 |-> ##2 (cfg_on_rs232 && !comm_on_rs485))
        else $error("config mode routing wrong");
    cfg_code_a: assert property (
        mode == 2'h1 |-> ##2 (disp_tens == 4'hC && disp_units == 4'hF))
        else $error("config code not shown");
    addr_pulse_a: assert property (
        addr_write |=> !addr_write)
        else $error("address write longer than one cycle");
    addr_range_a: assert property (
        addr_write |-> slave_addr <= 7'h63 && mode == 2'h0)
        else $error("accepted address out of range");
    digit_dec_a: assert property (
        mode == 2'h0 && disp_tens_on |-> disp_tens <= 4'h9)
        else $error("tens digit not decimal");
    lamp_idle_a: assert property (
        idle_cyc > 32'(100 * MS_CYC) |-> !ser_tx_led)
        else $error("transmit lamp lit while idle");
    lamp_start_a: assert property (
        $rose(ser_tx_busy) |-> ##[1:40] ser_tx_led)
        else $error("transmit lamp did not light");
endmodule : pmae_panel_asserts

bind pmae_panel pmae_panel_asserts #(.MS_CYC(MS_CYC)) pmae_panel_asserts_i (
    .clk(clk), .rst(rst), .ser_tx_busy(ser_tx_busy), .mode(mode),
    .comm_on_rs485(comm_on_rs485), .debug_on_rs232(debug_on_rs232),
    .cfg_on_rs232(cfg_on_rs232), .disp_tens(disp_tens),
    .disp_units(disp_units), .disp_tens_on(disp_tens_on),
    .slave_addr(slave_addr), .addr_write(addr_write),
    .ser_tx_led(ser_tx_led));
`default_nettype wire

/* File: verif/pmae_operator.sv */
`timescale 1ns/1ps
`default_nettype none

// *****
// Operator at the button, with contact chatter
// *****
module pmae_operator (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic [15:0] press_cyc,
    output logic             button,
    output logic             busy
);
    logic [15:0] cnt;

    // Press length plus three chatter cycles at each end
    always_ff @(posedge clk) begin
        if (rst) begin
            busy <= 1'b0;
            cnt  <= 16'h0000;
        end else if (go && !busy) begin
            busy <= 1'b1;
            cnt  <= press_cyc + 16'h0006;
        end else if (busy) begin
            cnt  <= cnt - 16'h0001;
            busy <= (cnt != 16'h0001);
        end
    end

    // Contacts chatter on make and on break
    always_comb begin
        if (!busy)
            button = 1'b0;
        else if (cnt > 16'h0003 && cnt <= press_cyc + 16'h0003)
            button = 1'b1;
        else
            button = cnt[0];
    end
endmodule : pmae_operator
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        sw_debug = 1'b0;
    logic        sw_config = 1'b0;
    logic [3:0]  stored_tens = 4'h0;
    logic [3:0]  stored_units = 4'h0;
    logic [3:0]  busy_in = 4'h0;
    logic        op_go = 1'b0;
    logic [15:0] op_len = 16'h0000;
    logic        button, op_busy, rs485, dbg232, cfg232;
    logic        tens_on, units_on, addr_write, tens_prev;
    logic [1:0]  mode;
    logic [3:0]  disp_tens, disp_units, leds;
    logic [6:0]  slave_addr;
    logic [7:0]  rows [4] = '{8'h00, 8'h29, 8'h56, 8'h69};
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          wr_cnt = 0;
    int          falls = 0;
    int          n_t, n_u;
    logic        seen;

    // *****
    // Design, operator and clock
    // *****
    pmae_panel #(.HOLD_MS(5), .IDLE_MS(20), .DBL_MS(8), .DEB_MS(2),
        .FLASH_MS(2), .MS_CYC(4)) pmae_panel_i (
        .clk(clk), .rst(rst), .sw_debug(sw_debug), .sw_config(sw_config),
        .button(button), .stored_tens(stored_tens),
        .stored_units(stored_units), .ser_tx_busy(busy_in[0]),
        .ser_rx_busy(busy_in[1]), .fb_tx_busy(busy_in[2]),
        .fb_rx_busy(busy_in[3]), .mode(mode), .comm_on_rs485(rs485),
        .debug_on_rs232(dbg232), .cfg_on_rs232(cfg232),
        .disp_tens(disp_tens), .disp_units(disp_units),
        .disp_tens_on(tens_on), .disp_units_on(units_on),
        .slave_addr(slave_addr), .addr_write(addr_write),
        .ser_tx_led(leds[0]), .ser_rx_led(leds[1]),
        .fb_tx_led(leds[2]), .fb_rx_led(leds[3]));

    pmae_operator pmae_operator_i (.clk(clk), .rst(rst), .go(op_go),
        .press_cyc(op_len), .button(button), .busy(op_busy));

    always #12.5 clk = ~clk;

    // Address store, write count, dark flashes, hang guard
    always @(posedge clk) begin
        tens_prev <= tens_on;
        falls <= (addr_write ? 0 : falls) + int'(tens_prev & ~tens_on);
        if (addr_write) begin
            wr_cnt <= wr_cnt + 1;
            stored_tens <= 4'(slave_addr / 10);
            stored_units <= 4'(slave_addr % 10);
        end
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // *****
    // Tasks
    // *****
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    task automatic do_reset;
        rst = 1'b1;
        step(20);
        check({tens_on, units_on, addr_write, 3'h0, mode}, 8'h00);
        rst = 1'b0;
        step(12);
    endtask : do_reset

    task automatic press(input int len, input int gap);
        op_len = 16'(len);
        op_go = 1'b1;
        step(1);
        op_go = 1'b0;
        for (int k = 0; k < 500 && op_busy; k++)
            step(1);
        step(gap);
    endtask : press

    // Count lit cycles of each digit over a window
    task automatic watch(input int n);
        n_t = 0;
        n_u = 0;
        repeat (n) begin
            step(1);
            n_t += int'(tens_on);
            n_u += int'(units_on);
        end
    endtask : watch

    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // *****
    // Main sequence
    // *****
    initial begin
        for (int i = 0; i < 4; i++) begin
            {sw_debug, sw_config} = rows[i][6:5];
            do_reset();
            check({3'h0, mode, rs485, dbg232, cfg232}, {3'h0, rows[i][4:0]});
            {sw_debug, sw_config} = ~rows[i][6:5];
            step(20);
            check({3'h0, mode, rs485, dbg232, cfg232}, {3'h0, rows[i][4:0]});
            if (rows[i][4:3] == 2'h1)
                check({disp_tens, disp_units}, 8'hCF);
        end
        // Run mode shows the stored address
        {sw_debug, sw_config} = 2'h0;
        {stored_tens, stored_units} = 8'h47;
        do_reset();
        check({disp_tens, disp_units}, 8'h47);
        check({1'b0, slave_addr}, 8'h2F);
        // Edit 99: both digits wrap, units stepped twice, accept 01
        {stored_tens, stored_units} = 8'h99;
        step(4);
        press(12, 8);
        press(12, 8);
        watch(40);
        check({7'h0, n_t > 0 && n_t < 40}, 8'h01);
        check(8'(n_u), 8'h28);
        press(12, 16);
        check({4'h0, disp_tens}, 8'h00);
        press(40, 4);
        watch(24);
        check(8'(n_t), 8'h18);
        check({7'h0, n_u > 0 && n_u < 24}, 8'h01);
        press(12, 12);
        press(12, 12);
        check({4'h0, disp_units}, 8'h01);
        press(40, 80);
        check(8'(wr_cnt), 8'h01);
        check(8'(falls), 8'h03);
        check({disp_tens, disp_units}, 8'h01);
        // Idle during edit abandons it
        press(12, 8);
        press(12, 8);
        press(12, 120);
        check(8'(wr_cnt), 8'h01);
        watch(16);
        check({disp_tens, disp_units, 8'(n_t + n_u)} >> 8, 16'h0001);
        check(8'(n_t + n_u), 8'h20);
        // Short transfer lights each lamp, idle lamp stays dark
        for (int i = 0; i < 4; i++) begin
            busy_in[i] = 1'b1;
            step(1);
            busy_in[i] = 1'b0;
            seen = 1'b0;
            repeat (150) begin
                step(1);
                seen |= leds[i];
            end
            check({7'h0, seen}, 8'h01);
            step(450);
            seen = 1'b0;
            repeat (50) begin
                step(1);
                seen |= leds[i];
            end
            check({7'h0, seen}, 8'h00);
        end
        print_verdict();
    end
endmodule : tb
`default_nettype wire
